//--- design/twd_pkg.sv
/*
  Package for the two-wire debug target register set: link register selects,
  unlock keys, flash command codes, special-function mirror location, reset
  values and the packed carrier of one link access.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package twd_pkg;

  // ----------------------------------------------------------------------
  // Link register selects
  // ----------------------------------------------------------------------
  localparam logic [7:0] SEL_PART_ID_ALT = 8'h00;
  localparam logic [7:0] SEL_REV_ALT     = 8'h01;
  localparam logic [7:0] SEL_PROG_CTL    = 8'h02;
  localparam logic [7:0] SEL_PROG_DATA   = 8'hB4;
  localparam logic [7:0] SEL_PART_ID     = 8'hFD;
  localparam logic [7:0] SEL_REV         = 8'hFE;

  // ----------------------------------------------------------------------
  // Special-function mirror and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] SFR_PART_ID     = 8'hFD;
  localparam logic [7:0] SFR_REV         = 8'hFE;
  localparam logic [7:0] SFR_ID_PAGE     = 8'h0F;
  localparam logic [7:0] RST_SEL         = 8'h00;
  localparam logic [7:0] RST_PROG_CTL    = 8'h00;
  localparam logic [7:0] RST_PROG_DATA   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;

  // ----------------------------------------------------------------------
  // Unlock keys and flash commands
  // ----------------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST       = 8'h02;
  localparam logic [7:0] KEY_SECOND      = 8'h01;
  localparam logic [7:0] CMD_BLOCK_READ  = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE  = 8'h08;
  localparam logic [7:0] CMD_DEV_ERASE   = 8'h03;

  typedef enum logic [4:0] {
    FC_NONE   = 5'b00001,
    FC_READ   = 5'b00010,
    FC_WRITE  = 5'b00100,
    FC_PERASE = 5'b01000,
    FC_DERASE = 5'b10000
  } twd_fcmd_t;

  // One access from the link's protocol engine, on the link clock.
  typedef struct packed {
    logic       sel_wr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } twd_lnk_req_t;

endpackage

//--- design/twd_regs.sv
/*
  Target-side register set of the two-wire debug and programming link.
  Assumes the link's bit-level engine runs on the link clock and hands one
  access per cycle as a packed request; the core side runs on mclk_i and
  takes flash bytes, returns read bytes and reports when it is halted.
*/
// Contract
// (RL1) Part id read-only, link 0xFD, SFR mirror.
// (RL2) Revision id read-only, from manufactured strap.
// (RL3) Revision at link 0xFE and SFR 0xFE.
// (RL4) Keys 0x02 then 0x01 unlock programming.
// (RL5) Programming mode holds until system reset.
// (RL6) Data register carries commands, addresses, data.
// (RL7) Accept commands 0x06, 0x07, 0x08, 0x03.
// (RL8) Flash traffic forwarded only while core halted.
// (RL9) Select register steers later data accesses.
// (RL10) Writes to id registers are ignored.
`timescale 1ns/1ps
module twd_regs #(
  parameter logic [7:0] PART_ID = 8'h5A // Arbitrary value, not a real part code.
) (
  input  wire logic                  mclk_i,        // Core clock, 25 MHz.
  input  wire logic                  nrst_i,        // System reset, async, active low.
  input  wire logic                  lnk_clk_i,     // Link clock from the debug pin.
  input  wire twd_pkg::twd_lnk_req_t lnk_req_i,     // Link access, link clock domain.
  output logic [7:0]                 lnk_rdata_o,   // Read data, valid after rd.
  output logic                       lnk_prog_o,    // Programming unlocked, link domain.
  input  wire logic [7:0]            rev_strap_i,   // Revision strap pins.
  input  wire logic                  halted_i,      // Core halted, mclk domain.
  output logic                       prog_mode_o,   // Programming unlocked, core domain.
  output logic                       fp_stb_o,      // One-cycle pulse: new flash byte.
  output logic [7:0]                 fp_byte_o,     // Flash byte from the host.
  output twd_pkg::twd_fcmd_t         fp_cmd_o,      // Decoded command of that byte.
  output logic                       fp_drop_o,     // Pulse: byte dropped, core running.
  input  wire logic                  resp_stb_i,    // Pulse: core returns a byte.
  input  wire logic [7:0]            resp_data_i,   // Byte returned to the host.
  input  wire logic [7:0]            sfr_addr_i,    // Core SFR read address.
  input  wire logic [7:0]            sfr_page_i,    // Core SFR page.
  output logic [7:0]                 sfr_rdata_o    // SFR mirror read data.
);

  function automatic twd_pkg::twd_fcmd_t decode_cmd(input logic [7:0] b);
    case (b)
      twd_pkg::CMD_BLOCK_READ:  decode_cmd = twd_pkg::FC_READ;
      twd_pkg::CMD_BLOCK_WRITE: decode_cmd = twd_pkg::FC_WRITE;
      twd_pkg::CMD_PAGE_ERASE:  decode_cmd = twd_pkg::FC_PERASE;
      twd_pkg::CMD_DEV_ERASE:   decode_cmd = twd_pkg::FC_DERASE;
      default:                  decode_cmd = twd_pkg::FC_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Link-domain reset
  // ----------------------------------------------------------------------
  // The link clock may stop, so reset is released synchronously to it.
  logic lrst_a_ff;
  logic lrst_n_ff;
  always_ff @(posedge lnk_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lrst_a_ff <= 1'b0;
      lrst_n_ff <= 1'b0;
    end else begin
      lrst_a_ff <= 1'b1;
      lrst_n_ff <= lrst_a_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Revision strap capture, once per reset in each domain
  // ----------------------------------------------------------------------
  logic [7:0] lrev_a_ff;
  logic [7:0] lrev_b_ff;
  logic [7:0] lrev_ff;
  logic [1:0] lrev_cnt_ff;
  // The strap takes two edges to cross, so the latch follows the synchroniser
  // for three edges and keeps what the third one brings.
  always_ff @(posedge lnk_clk_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      lrev_a_ff   <= 8'h00;
      lrev_b_ff   <= 8'h00;
      lrev_ff     <= 8'h00;
      lrev_cnt_ff <= 2'h0;
    end else begin
      lrev_a_ff <= rev_strap_i;
      lrev_b_ff <= lrev_a_ff;
      if (lrev_cnt_ff != 2'h3) begin
        lrev_cnt_ff <= lrev_cnt_ff + 2'h1;
        lrev_ff     <= lrev_b_ff; // RL2
      end
    end
  end

  logic [7:0] crev_a_ff;
  logic [7:0] crev_b_ff;
  logic [7:0] crev_ff;
  logic [1:0] crev_cnt_ff;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crev_a_ff   <= 8'h00;
      crev_b_ff   <= 8'h00;
      crev_ff     <= 8'h00;
      crev_cnt_ff <= 2'h0;
    end else begin
      crev_a_ff <= rev_strap_i;
      crev_b_ff <= crev_a_ff;
      if (crev_cnt_ff != 2'h3) begin
        crev_cnt_ff <= crev_cnt_ff + 2'h1;
        crev_ff     <= crev_b_ff; // RL2
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link-side registers
  // ----------------------------------------------------------------------
  logic [7:0] sel_ff;
  logic [7:0] ctl_ff;
  logic [7:0] dat_ff;
  logic       key1_ff;
  logic       prog_ff;
  logic       fwd_tgl_ff;
  logic [2:0] rsp_sync_ff;
  logic [7:0] resp_hold_ff;
  logic       rsp_tgl_ff;
  wire        wr_ctl = lnk_req_i.wr && (sel_ff == twd_pkg::SEL_PROG_CTL);
  wire        wr_dat = lnk_req_i.wr && (sel_ff == twd_pkg::SEL_PROG_DATA);
  wire        rsp_ev = rsp_sync_ff[2] ^ rsp_sync_ff[1];

  always_ff @(posedge lnk_clk_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      sel_ff <= twd_pkg::RST_SEL;
    end else if (lnk_req_i.sel_wr) begin
      sel_ff <= lnk_req_i.wdata; // RL9
    end
  end

  // Unlock: the first key arms, the second completes; any other control write disarms.
  always_ff @(posedge lnk_clk_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      ctl_ff  <= twd_pkg::RST_PROG_CTL;
      key1_ff <= 1'b0;
      prog_ff <= 1'b0;
    end else if (wr_ctl) begin
      ctl_ff  <= lnk_req_i.wdata;
      key1_ff <= (lnk_req_i.wdata == twd_pkg::KEY_FIRST); // RL4
      if (key1_ff && (lnk_req_i.wdata == twd_pkg::KEY_SECOND)) begin
        prog_ff <= 1'b1; // RL4 RL5
      end
    end
  end

  // A byte returned by the core wins over a host write in the same cycle.
  always_ff @(posedge lnk_clk_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      dat_ff     <= twd_pkg::RST_PROG_DATA;
      fwd_tgl_ff <= 1'b0;
    end else if (rsp_ev) begin
      dat_ff <= resp_hold_ff; // RL6
    end else if (wr_dat) begin
      dat_ff <= lnk_req_i.wdata; // RL6
      if (prog_ff) begin
        fwd_tgl_ff <= ~fwd_tgl_ff;
      end
    end
  end

  always_ff @(posedge lnk_clk_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      lnk_rdata_o <= twd_pkg::RD_UNMAPPED;
      lnk_prog_o  <= 1'b0;
      rsp_sync_ff <= 3'h0;
    end else begin
      lnk_prog_o  <= prog_ff;
      rsp_sync_ff <= {rsp_sync_ff[1:0], rsp_tgl_ff};
      if (lnk_req_i.rd) begin
        case (sel_ff)
          twd_pkg::SEL_PART_ID, twd_pkg::SEL_PART_ID_ALT: lnk_rdata_o <= PART_ID; // RL1 RL10
          twd_pkg::SEL_REV, twd_pkg::SEL_REV_ALT:         lnk_rdata_o <= lrev_ff; // RL3 RL10
          twd_pkg::SEL_PROG_CTL:                          lnk_rdata_o <= ctl_ff;
          twd_pkg::SEL_PROG_DATA:                         lnk_rdata_o <= dat_ff;
          default:                                        lnk_rdata_o <= twd_pkg::RD_UNMAPPED;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Core side: flash byte forwarding and returned data
  // ----------------------------------------------------------------------
  // The forwarded byte is dat_ff itself; the host leaves it still for a few
  // core cycles after each write, which keeps the crossing free of a FIFO.
  logic [2:0] fwd_sync_ff;
  logic [1:0] prog_sync_ff;
  wire        fwd_ev = fwd_sync_ff[2] ^ fwd_sync_ff[1];

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwd_sync_ff  <= 3'h0;
      prog_sync_ff <= 2'h0;
      prog_mode_o  <= 1'b0;
      fp_stb_o     <= 1'b0;
      fp_drop_o    <= 1'b0;
      fp_byte_o    <= 8'h00;
      fp_cmd_o     <= twd_pkg::FC_NONE;
    end else begin
      fwd_sync_ff  <= {fwd_sync_ff[1:0], fwd_tgl_ff};
      prog_sync_ff <= {prog_sync_ff[0], prog_ff};
      prog_mode_o  <= prog_sync_ff[1];
      fp_stb_o     <= fwd_ev && halted_i; // RL8
      fp_drop_o    <= fwd_ev && !halted_i; // RL8
      if (fwd_ev) begin
        fp_byte_o <= dat_ff; // RL6
        fp_cmd_o  <= decode_cmd(dat_ff); // RL7
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_tgl_ff   <= 1'b0;
      resp_hold_ff <= 8'h00;
    end else if (resp_stb_i) begin
      rsp_tgl_ff   <= ~rsp_tgl_ff;
      resp_hold_ff <= resp_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_page_i == twd_pkg::SFR_ID_PAGE && sfr_addr_i == twd_pkg::SFR_PART_ID) begin
      sfr_rdata_o <= PART_ID; // RL1
    end else if (sfr_page_i == twd_pkg::SFR_ID_PAGE && sfr_addr_i == twd_pkg::SFR_REV) begin
      sfr_rdata_o <= crev_ff; // RL3
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_unlock_pair: assert property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) // RL4
    (wr_ctl && lnk_req_i.wdata == twd_pkg::KEY_FIRST && !prog_ff) ##1 lnk_req_i.sel_wr ##1
    (wr_ctl && lnk_req_i.wdata == twd_pkg::KEY_SECOND) |=> prog_ff)
    else $error("Ordered keys did not unlock programming.");

  a_unlock_cause: assert property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) // RL4
    $rose(prog_ff) |-> $past(wr_ctl && key1_ff && lnk_req_i.wdata == twd_pkg::KEY_SECOND))
    else $error("Programming unlocked without the key pair.");

  a_prog_held: assert property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) // RL5
    prog_ff |=> prog_ff [*8])
    else $error("Programming mode dropped without reset.");

  a_part_id_rd: assert property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) // RL1
    (lnk_req_i.rd && sel_ff == twd_pkg::SEL_PART_ID) |=> lnk_rdata_o == PART_ID)
    else $error("Part id read returned a wrong value.");

  a_rev_rd: assert property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) // RL3
    (lnk_req_i.rd && sel_ff == twd_pkg::SEL_REV) |=> lnk_rdata_o == lrev_ff)
    else $error("Revision read returned a wrong value.");

  a_id_wr_ignored: assert property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) // RL10
    (lnk_req_i.wr && (sel_ff == twd_pkg::SEL_PART_ID || sel_ff == twd_pkg::SEL_REV))
    |=> $stable(ctl_ff) && $stable(dat_ff) && $stable(prog_ff))
    else $error("Write to an id register changed state.");

  a_sel_steers: assert property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) // RL9
    lnk_req_i.sel_wr ##1 (lnk_req_i.rd && !lnk_req_i.sel_wr && sel_ff == twd_pkg::SEL_PROG_CTL)
    |=> lnk_rdata_o == ctl_ff)
    else $error("Selected register not reached by read.");

  a_data_wr: assert property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) // RL6
    (wr_dat && !rsp_ev) |=> dat_ff == $past(lnk_req_i.wdata))
    else $error("Data register did not take the host byte.");

  a_cmd_decode: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RL7
    (fp_stb_o && fp_byte_o == twd_pkg::CMD_BLOCK_WRITE) |-> fp_cmd_o == twd_pkg::FC_WRITE)
    else $error("Block write code not decoded.");

  a_halt_gate: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RL8
    fwd_ev |=> (fp_stb_o == $past(halted_i)) && (fp_drop_o != $past(halted_i)))
    else $error("Flash byte forwarded while core running.");

  a_sfr_rev: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RL3
    (sfr_page_i == twd_pkg::SFR_ID_PAGE && sfr_addr_i == twd_pkg::SFR_REV) |=> sfr_rdata_o == crev_ff)
    else $error("Revision mirror read wrong.");

  c_unlock:  cover property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) $rose(prog_ff));
  c_fwd:     cover property (@(posedge mclk_i) disable iff (!nrst_i) fp_stb_o && fp_cmd_o == twd_pkg::FC_READ);
  c_resp:    cover property (@(posedge lnk_clk_i) disable iff (!lrst_n_ff) rsp_ev);
  c_drop:    cover property (@(posedge mclk_i) disable iff (!nrst_i) fp_drop_o);

endmodule

//--- testbench/twd_host.sv
/*
  Host adapter model: makes the link clock and issues link accesses.
  Assumes the target takes a request on the rising link edge.
*/
`timescale 1ns/1ps
module twd_host (
  output logic                  lnk_clk_o,  // Link clock, stands high between frames.
  output twd_pkg::twd_lnk_req_t lnk_req_o,  // Access to the target.
  input  wire logic [7:0]       lnk_rdata_i // Read data from the target.
);
  logic [7:0] last_d;

  initial begin
    lnk_clk_o = 1'b1;
    last_d    = 8'h00;
    lnk_req_o = '0;
  end

  // One 80 ns cycle; the request stands until the rising edge that takes it.
  task automatic cyc(input logic s, input logic w, input logic r, input logic [7:0] d);
    lnk_req_o = '{sel_wr: s, wr: w, rd: r, wdata: d};
    last_d    = d;
    #31 lnk_clk_o = 1'b0;
    #40 lnk_clk_o = 1'b1;
    #9;
  endtask

  // Idle data lines flip every cycle so that stale data cannot pass for a hold.
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 1'b0, ~last_d);
  endtask

  task automatic wr_reg(input logic [7:0] sel, input logic [7:0] d);
    cyc(1'b1, 1'b0, 1'b0, sel);
    cyc(1'b0, 1'b1, 1'b0, d);
  endtask

  task automatic rd_reg(input logic [7:0] sel, output logic [7:0] q);
    cyc(1'b1, 1'b0, 1'b0, sel);
    cyc(1'b0, 1'b0, 1'b1, ~sel);
    idle(1);
    q = lnk_rdata_i;
  endtask

  task automatic unlock();
    wr_reg(twd_pkg::SEL_PROG_CTL, twd_pkg::KEY_FIRST);
    wr_reg(twd_pkg::SEL_PROG_CTL, twd_pkg::KEY_SECOND);
  endtask
endmodule

//--- testbench/tb_top.sv
/*
  Self-checking bench of the debug target register set.
  Assumes twd_pkg, twd_regs and the host model twd_host are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, e, g)
module tb_top;
  localparam logic [7:0] PID = 8'h5A; // Arbitrary value, not a real part code.
  localparam logic [7:0] ID_SEL [4] = '{8'hFD, 8'h00, 8'hFE, 8'h01};
  localparam logic [7:0] CMDS [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
  localparam logic [7:0] BAD [4] = '{8'h01, 8'h02, 8'h55, 8'h01};
  logic                  mclk_i, nrst_i, lnk_clk_i, halted_i, resp_stb_i;
  logic                  lnk_prog_o, prog_mode_o, fp_stb_o, fp_drop_o, got;
  logic [7:0]            rev_strap_i, resp_data_i, sfr_addr_i, sfr_page_i;
  logic [7:0]            lnk_rdata_o, fp_byte_o, sfr_rdata_o, q, b, ex;
  twd_pkg::twd_lnk_req_t lnk_req_i;
  twd_pkg::twd_fcmd_t    fp_cmd_o;
  int                    err_count, n_compared, seed;

  twd_regs #(.PART_ID(PID)) i_dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .lnk_clk_i(lnk_clk_i), .lnk_req_i(lnk_req_i),
    .lnk_rdata_o(lnk_rdata_o), .lnk_prog_o(lnk_prog_o), .rev_strap_i(rev_strap_i),
    .halted_i(halted_i), .prog_mode_o(prog_mode_o), .fp_stb_o(fp_stb_o), .fp_byte_o(fp_byte_o),
    .fp_cmd_o(fp_cmd_o), .fp_drop_o(fp_drop_o), .resp_stb_i(resp_stb_i), .resp_data_i(resp_data_i),
    .sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i), .sfr_rdata_o(sfr_rdata_o));
  twd_host i_host (.lnk_clk_o(lnk_clk_i), .lnk_req_o(lnk_req_i), .lnk_rdata_i(lnk_rdata_o));

  always #20 mclk_i = ~mclk_i;

  function automatic twd_pkg::twd_fcmd_t exp_cmd(input logic [7:0] c);
    case (c)
      twd_pkg::CMD_BLOCK_READ:  return twd_pkg::FC_READ;
      twd_pkg::CMD_BLOCK_WRITE: return twd_pkg::FC_WRITE;
      twd_pkg::CMD_PAGE_ERASE:  return twd_pkg::FC_PERASE;
      twd_pkg::CMD_DEV_ERASE:   return twd_pkg::FC_DERASE;
      default:                  return twd_pkg::FC_NONE;
    endcase
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      #2;
    end
  endtask

  // Both domains must see edges while reset is low, so the link clock runs here.
  task automatic do_reset();
    nrst_i = 1'b0;
    fork
      repeat (6) @(posedge mclk_i);
      i_host.idle(4);
    join
    @(posedge mclk_i);
    #2 nrst_i = 1'b1;
    i_host.idle(3);
    tick(4);
  endtask

  task automatic wait_fp(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 12 && !seen; i++) begin
      tick(1);
      seen = fp_stb_o === 1'b1 || fp_drop_o === 1'b1;
    end
  endtask

  initial begin
    seed = 32'h1dd17097;
    {mclk_i, nrst_i, halted_i, resp_stb_i} = 4'h0;
    {resp_data_i, sfr_addr_i, sfr_page_i} = 24'h000000;
    err_count = 0;
    n_compared = 0;
    rev_strap_i = 8'($random(seed));
    do_reset();
    i_host.rd_reg(twd_pkg::SEL_PROG_CTL, q);
    `CHK("ctl_reset", twd_pkg::RST_PROG_CTL, q);
    i_host.rd_reg(twd_pkg::SEL_PROG_DATA, q);
    `CHK("data_reset", twd_pkg::RST_PROG_DATA, q);
    `CHK("prog_reset", 8'h00, {lnk_prog_o, prog_mode_o});
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      i_host.wr_reg(ID_SEL[i], 8'($random(seed)));
      i_host.rd_reg(ID_SEL[i], q);
      `CHK("id_read", (i < 2) ? PID : rev_strap_i, q);
    end
    i_host.rd_reg(8'h33, q);
    `CHK("unmapped_read", twd_pkg::RD_UNMAPPED, q);
    for (int i = 0; i < 3; i++) begin
      sfr_page_i = (i < 2) ? twd_pkg::SFR_ID_PAGE : 8'h00;
      sfr_addr_i = (i == 1) ? twd_pkg::SFR_REV : twd_pkg::SFR_PART_ID;
      ex = (i == 0) ? PID : (i == 1) ? rev_strap_i : twd_pkg::RD_UNMAPPED;
      tick(2);
      `CHK("sfr_mirror", ex, sfr_rdata_o);
    end
    $display("test identification done");
    halted_i = 1'b1;
    i_host.wr_reg(twd_pkg::SEL_PROG_DATA, twd_pkg::CMD_BLOCK_WRITE);
    wait_fp(got);
    `CHK("fwd_locked", 8'h00, got);
    for (int i = 0; i < 4; i++) i_host.wr_reg(twd_pkg::SEL_PROG_CTL, BAD[i]);
    i_host.idle(3);
    `CHK("prog_bad_order", 8'h00, lnk_prog_o);
    i_host.unlock();
    i_host.idle(3);
    `CHK("lnk_prog", 8'h01, lnk_prog_o);
    tick(6);
    `CHK("prog_mode", 8'h01, prog_mode_o);
    $display("test unlock done");
    for (int i = 0; i < 6; i++) begin
      b = (i < 4) ? CMDS[i] : 8'($random(seed));
      halted_i = i < 5;
      i_host.wr_reg(twd_pkg::SEL_PROG_DATA, b);
      wait_fp(got);
      `CHK("fwd_seen", 8'h01, got);
      if (!got) finish_test();
      `CHK("fwd_stb", 8'(i < 5), fp_stb_o);
      `CHK("fwd_drop", 8'(i == 5), fp_drop_o);
      `CHK("fwd_byte", b, fp_byte_o);
      `CHK("fwd_cmd", exp_cmd(b), fp_cmd_o);
      tick(4);
    end
    halted_i = 1'b1;
    b = 8'($random(seed));
    resp_stb_i = 1'b1;
    resp_data_i = b;
    tick(1);
    resp_stb_i = 1'b0;
    i_host.idle(5);
    i_host.rd_reg(twd_pkg::SEL_PROG_DATA, q);
    `CHK("core_return", b, q);
    $display("test flash traffic done");
    i_host.wr_reg(twd_pkg::SEL_PROG_CTL, 8'h00);
    i_host.idle(3);
    `CHK("prog_sticky", 8'h03, {lnk_prog_o, prog_mode_o});
    rev_strap_i = rev_strap_i ^ (8'($random(seed)) | 8'h01);
    do_reset();
    `CHK("prog_cleared", 8'h00, {lnk_prog_o, prog_mode_o});
    i_host.idle(2);
    i_host.rd_reg(twd_pkg::SEL_REV, q);
    `CHK("rev_new_strap", rev_strap_i, q);
    sfr_page_i = twd_pkg::SFR_ID_PAGE;
    sfr_addr_i = twd_pkg::SFR_REV;
    tick(2);
    `CHK("sfr_new_strap", rev_strap_i, sfr_rdata_o);
    $display("test sticky mode done");
    finish_test();
  end
endmodule
